//--- verilog/rmls_top.v
// How it works
// - 7-bit receiver address; zero blocks access
// - Address auto-loaded after lock unless held
// - Hold bit set suppresses auto-load
// - Alias match replaced by target; zero blocks
// - 7-bit alias stored; zero disables slave
// - 16-bit CRC counter, cleared by reset control
// - Sticky link-lost flag until reset control
// - Self-test CRC flag, three clear causes
// - Status bit 2 shows input clock
// - Normal CRC flag, cleared by loss/reset
// - Status bit 0 shows link detect
`timescale 1ns/10ps
`include "rmls_regs.vh"
module rmls_top (
    // Clock, reset, enable
    input  wire       mclk,
    input  wire       rst,
    input  wire       ce,
    // Register port
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // Control channel events
    input  wire       rx_lock,
    input  wire [6:0] cc_rx_addr,
    input  wire       crc_err_pulse,
    input  wire       selftest_active,
    input  wire       selftest_start,
    input  wire       link_lost_pulse,
    input  wire       crc_clear,
    // Status pins
    input  wire       input_clock_present,
    input  wire       link_detect_pin,
    // Local I2C request
    input  wire       req_valid,
    input  wire [6:0] req_addr,
    // Forwarded request
    output wire       fwd_valid,
    output wire [6:0] fwd_addr,
    output wire       fwd_block
);
    reg  [6:0]  remote_receiver_address_r;
    reg         hold_receiver_address_r;
    reg  [6:0]  remote_target_address_r;
    reg  [6:0]  local_match_address_r;
    reg  [15:0] crc_count_r;
    reg         link_lost_r;
    reg         selftest_crc_error_flag_r;
    reg         normal_crc_error_r;
    reg         lock_d_r;
    wire        clk_ok;
    wire        link_ok;
    wire        lock_rise;
    wire [7:0]  status_byte;

    // Pin synchronisers
    rmls_sync3 u_sync_clk (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .pin_in    (input_clock_present),
        .level_out (clk_ok)
    );
    rmls_sync3 u_sync_link (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .pin_in    (link_detect_pin),
        .level_out (link_ok)
    );

    // Lock edge detect
    assign lock_rise = rx_lock & ~lock_d_r;
    always @(posedge mclk) begin
        if (rst) begin
            lock_d_r <= 1'b0;
        end else if (ce) begin
            lock_d_r <= rx_lock;
        end
    end

    // Receiver address and hold bit
    always @(posedge mclk) begin
        if (rst) begin
            remote_receiver_address_r <= `RMLS_RST_ADDR7;
            hold_receiver_address_r   <= 1'b0;
        end else if (ce) begin
            if (reg_wr && reg_addr == `RMLS_OFS_RX_ADDR) begin
                remote_receiver_address_r <= reg_wdata[`RMLS_ADDR_MSB:`RMLS_ADDR_LSB];
                hold_receiver_address_r   <= reg_wdata[`RMLS_HOLD_BIT];
            end else if (lock_rise && !hold_receiver_address_r) begin
                remote_receiver_address_r <= cc_rx_addr;
            end
        end
    end

    // Target and alias addresses
    always @(posedge mclk) begin
        if (rst) begin
            remote_target_address_r <= `RMLS_RST_ADDR7;
            local_match_address_r   <= `RMLS_RST_ADDR7;
        end else if (ce && reg_wr) begin
            if (reg_addr == `RMLS_OFS_TGT_ADDR) begin
                remote_target_address_r <= reg_wdata[`RMLS_ADDR_MSB:`RMLS_ADDR_LSB];
            end
            if (reg_addr == `RMLS_OFS_ALIAS_ADDR) begin
                local_match_address_r <= reg_wdata[`RMLS_ADDR_MSB:`RMLS_ADDR_LSB];
            end
        end
    end

    // CRC error counter, saturating
    always @(posedge mclk) begin
        if (rst) begin
            crc_count_r <= `RMLS_RST_CNT;
        end else if (ce) begin
            if (crc_clear) begin
                crc_count_r <= `RMLS_RST_CNT;
            end else if (crc_err_pulse && crc_count_r != `RMLS_CNT_MAX) begin
                crc_count_r <= crc_count_r + `RMLS_CNT_ONE;
            end
        end
    end

    // Sticky status flags; a new event wins over its clear
    always @(posedge mclk) begin
        if (rst) begin
            link_lost_r               <= 1'b0;
            selftest_crc_error_flag_r <= 1'b0;
            normal_crc_error_r        <= 1'b0;
        end else if (ce) begin
            if (link_lost_pulse) begin
                link_lost_r <= 1'b1;
            end else if (crc_clear) begin
                link_lost_r <= 1'b0;
            end
            if (crc_err_pulse && selftest_active) begin
                selftest_crc_error_flag_r <= 1'b1;
            end else if (link_lost_pulse || selftest_start || crc_clear) begin
                selftest_crc_error_flag_r <= 1'b0;
            end
            if (crc_err_pulse && !selftest_active) begin
                normal_crc_error_r <= 1'b1;
            end else if (link_lost_pulse || crc_clear) begin
                normal_crc_error_r <= 1'b0;
            end
        end
    end

    // Status byte assembly
    // self-test in bit 3
    assign status_byte = {3'h0, link_lost_r, selftest_crc_error_flag_r,
                          clk_ok, normal_crc_error_r, link_ok};

    // Registered read data; unmapped offsets read zero
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= `RMLS_RST_BYTE;
        end else if (ce && reg_rd) begin
            case (reg_addr)
                `RMLS_OFS_RX_ADDR:    reg_rdata <= {remote_receiver_address_r,
                                                    hold_receiver_address_r};
                `RMLS_OFS_TGT_ADDR:   reg_rdata <= {remote_target_address_r, 1'b0};
                `RMLS_OFS_ALIAS_ADDR: reg_rdata <= {local_match_address_r, 1'b0};
                `RMLS_OFS_CRC_LO:     reg_rdata <= crc_count_r[7:0];
                `RMLS_OFS_CRC_HI:     reg_rdata <= crc_count_r[15:8];
                `RMLS_OFS_STATUS:     reg_rdata <= status_byte;
                default:              reg_rdata <= `RMLS_RST_BYTE;
            endcase
        end
    end

    // Remap of local requests toward the link
    // receiver gate
    rmls_remap u_remap (
        .mclk       (mclk),
        .rst        (rst),
        .ce         (ce),
        .rx_addr    (remote_receiver_address_r),
        .tgt_addr   (remote_target_address_r),
        .alias_addr (local_match_address_r),
        .req_valid  (req_valid),
        .req_addr   (req_addr),
        .fwd_valid  (fwd_valid),
        .fwd_addr   (fwd_addr),
        .fwd_block  (fwd_block)
    );
endmodule // rmls_top

//--- verilog/rmls_regs.vh
`ifndef RMLS_REGS_VH
`define RMLS_REGS_VH
// Register offsets
`define RMLS_OFS_RX_ADDR    8'h06
`define RMLS_OFS_TGT_ADDR   8'h07
`define RMLS_OFS_ALIAS_ADDR 8'h08
`define RMLS_OFS_CRC_LO     8'h0A
`define RMLS_OFS_CRC_HI     8'h0B
`define RMLS_OFS_STATUS     8'h0C
// Field positions
`define RMLS_ADDR_MSB       7
`define RMLS_ADDR_LSB       1
`define RMLS_HOLD_BIT       0
`define RMLS_ST_LOST_BIT    4
`define RMLS_ST_SELFTEST    3
`define RMLS_ST_CLK_BIT     2
`define RMLS_ST_NORM_BIT    1
`define RMLS_ST_LINK_BIT    0
// Reset values
`define RMLS_RST_BYTE       8'h00
`define RMLS_RST_ADDR7      7'h00
`define RMLS_RST_CNT        16'h0000
`define RMLS_CNT_ONE        16'h0001
`define RMLS_CNT_MAX        16'hFFFF
`endif

//--- verilog/rmls_sync3.v
`timescale 1ns/10ps
// Three-stage pin synchroniser; output changes when stages two and three agree
module rmls_sync3 (
    // Clock and control
    input  wire mclk,
    input  wire rst,
    input  wire ce,
    // Pin in, clean level out
    input  wire pin_in,
    output reg  level_out
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // Shift chain and agreement filter
    always @(posedge mclk) begin
        if (rst) begin
            s1_r      <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            level_out <= 1'b0;
        end else if (ce) begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule // rmls_sync3

//--- verilog/rmls_remap.v
`timescale 1ns/10ps
`include "rmls_regs.vh"
// Address remap for one local I2C request: alias to target, receiver pass-through
module rmls_remap (
    // Clock and control
    input  wire       mclk,
    input  wire       rst,
    input  wire       ce,
    // Stored addresses
    input  wire [6:0] rx_addr,
    input  wire [6:0] tgt_addr,
    input  wire [6:0] alias_addr,
    // Local request
    input  wire       req_valid,
    input  wire [6:0] req_addr,
    // Forwarded request
    output reg        fwd_valid,
    output reg  [6:0] fwd_addr,
    output reg        fwd_block
);
    // Registered remap decision
    always @(posedge mclk) begin
        if (rst) begin
            fwd_valid <= 1'b0;
            fwd_addr  <= `RMLS_RST_ADDR7;
            fwd_block <= 1'b0;
        end else if (ce) begin
            fwd_valid <= 1'b0;
            fwd_block <= 1'b0;
            if (req_valid) begin
                if (alias_addr != `RMLS_RST_ADDR7 && req_addr == alias_addr) begin
                    fwd_addr <= tgt_addr;
                    if (tgt_addr == `RMLS_RST_ADDR7) begin
                        fwd_block <= 1'b1;
                    end else begin
                        fwd_valid <= 1'b1;
                    end
                end else if (req_addr == rx_addr) begin
                    fwd_addr <= rx_addr;
                    if (rx_addr == `RMLS_RST_ADDR7) begin
                        fwd_block <= 1'b1;
                    end else begin
                        fwd_valid <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // rmls_remap

//--- dv/rmls_top_properties.sv
`timescale 1ns/10ps
// Watches remap and status reads against shadow copies of the map
module rmls_chk (
    // Clock and register port
    input wire       mclk, rst, ce, reg_wr, reg_rd,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata,
    // Events and request
    input wire       crc_err_pulse, selftest_active, selftest_start,
    input wire       link_lost_pulse, crc_clear, req_valid, fwd_valid, fwd_block,
    // Addresses
    input wire [6:0] req_addr, fwd_addr
);
    reg  [6:0] tgt_r, alias_r;
    wire       hit  = ce && req_valid && alias_r != 7'h00 && req_addr == alias_r;
    wire       calm = !crc_clear && !link_lost_pulse && !selftest_start && !crc_err_pulse;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Shadow target and alias fields
    always @(posedge mclk) begin
        if (rst) begin
            tgt_r   <= 7'h00;
            alias_r <= 7'h00;
        end else if (ce && reg_wr && reg_addr == 8'h07) begin
            tgt_r <= reg_wdata[7:1];
        end else if (ce && reg_wr && reg_addr == 8'h08) begin
            alias_r <= reg_wdata[7:1];
        end
    end
    // Quiet cycle, then a status read
    sequence s_stat;
        calm ##1 ce && reg_rd && reg_addr == 8'h0C;
    endsequence
    AST_ALIAS_FWD: assert property (hit && tgt_r != 7'h00 |=> fwd_valid && fwd_addr == tgt_r)
        else $error("alias not remapped");
    AST_TGT_ZERO: assert property (hit && tgt_r == 7'h00 |=> fwd_block && !fwd_valid)
        else $error("zero target not blocked");
    AST_ONE_OUT: assert property (!(fwd_valid && fwd_block))
        else $error("forward and block together");
    AST_STAT_RSV: assert property (ce && reg_rd && reg_addr == 8'h0C |=> reg_rdata[7:5] == 3'h0)
        else $error("status reserved bits set");
    AST_CNT_CLR: assert property (ce && crc_clear ##1 !crc_err_pulse
        ##1 ce && reg_rd && reg_addr == 8'h0A |=> reg_rdata == 8'h00)
        else $error("counter not cleared");
    AST_LOST_SET: assert property (ce && link_lost_pulse ##1 s_stat |=> reg_rdata[4])
        else $error("link lost flag missing");
    AST_NORM_SET: assert property (ce && crc_err_pulse && !selftest_active ##1 s_stat |=> reg_rdata[1])
        else $error("normal error flag missing");
    AST_ST_SET: assert property (ce && crc_err_pulse && selftest_active ##1 s_stat |=> reg_rdata[3])
        else $error("self-test error flag missing");
    AST_LOST_CLR: assert property (ce && link_lost_pulse && !crc_err_pulse ##1 s_stat
        |=> !reg_rdata[3] && !reg_rdata[1])
        else $error("error flags survive link loss");
endmodule // rmls_chk
bind rmls_top rmls_chk u_chk (.*);

//--- dv/rmls_far_model.sv
`timescale 1ns/10ps
// Remote receiver stand-in: lock, back-channel errors, link loss
module rmls_far_model (
    // Clock
    input  wire       mclk,
    // Control channel events
    output reg        rx_lock, crc_err_pulse, selftest_active, link_lost_pulse,
    output reg  [6:0] cc_rx_addr
);
    // Idle state
    initial begin
        rx_lock = 1'b0;
        crc_err_pulse = 1'b0;
        selftest_active = 1'b0;
        link_lost_pulse = 1'b0;
        cc_rx_addr = 7'h55;
    end
    // Relock offering an address; the offer goes stale afterwards
    task lock(input [6:0] a);
        begin
            @(negedge mclk) rx_lock = 1'b0;
            cc_rx_addr = a;
            @(negedge mclk) rx_lock = 1'b1;
            repeat (3) @(negedge mclk);
            cc_rx_addr = ~a;
        end
    endtask
    // Burst of n back-channel errors
    task errs(input integer n, input st);
        begin
            @(negedge mclk) selftest_active = st;
            crc_err_pulse = 1'b1;
            repeat (n) @(negedge mclk);
            crc_err_pulse = 1'b0;
            selftest_active = 1'b0;
        end
    endtask
    // One loss-of-link event
    task lose;
        begin
            @(negedge mclk) link_lost_pulse = 1'b1;
            @(negedge mclk) link_lost_pulse = 1'b0;
        end
    endtask
endmodule // rmls_far_model

//--- dv/tb.sv
`timescale 1ns/10ps
// Bench for receiver address, remap and link status
module tb;
    reg        mclk, rst, ce, reg_wr, reg_rd, selftest_start, crc_clear;
    reg        input_clock_present, link_detect_pin, req_valid;
    reg  [7:0] reg_addr, reg_wdata;
    reg  [6:0] req_addr;
    wire [7:0] reg_rdata;
    wire       rx_lock, crc_err_pulse, selftest_active, link_lost_pulse, fwd_valid, fwd_block;
    wire [6:0] cc_rx_addr, fwd_addr;
    integer    err_count, total_checks, i;
    rmls_top dut (.*);
    rmls_far_model far (.*);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task chk(input string nm, input [7:0] seen, exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("Error %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, d);
        begin
            @(negedge mclk) reg_wr = 1'b1;
            reg_addr = a;
            reg_wdata = d;
            @(negedge mclk) reg_wr = 1'b0;
        end
    endtask
    // Read strobe, answer sampled one cycle later
    task rc(input [7:0] a, exp);
        begin
            @(negedge mclk) reg_rd = 1'b1;
            reg_addr = a;
            @(negedge mclk) reg_rd = 1'b0;
            chk("reg", reg_rdata, exp);
        end
    endtask
    task req(input [6:0] a, input ev, eb, input [6:0] ea);
        begin
            @(negedge mclk) req_valid = 1'b1;
            req_addr = a;
            @(negedge mclk) req_valid = 1'b0;
            chk("fwd", {fwd_valid, ev ? fwd_addr : 7'h00}, {ev, ea});
            chk("blk", {7'h00, fwd_block}, {7'h00, eb});
        end
    endtask
    task pulse_ctl(input sel);
        begin
            @(negedge mclk) if (sel) crc_clear = 1'b1; else selftest_start = 1'b1;
            @(negedge mclk) crc_clear = 1'b0;
            selftest_start = 1'b0;
        end
    endtask
    task t_reset;
        begin
            for (i = 0; i < 7; i = i + 1) rc(8'h06 + i[7:0], 8'h00);
            wr(8'h0B, 8'hFF);
            rc(8'h0B, 8'h00);
            $display("t_reset done");
        end
    endtask
    task t_auto;
        begin
            far.lock(7'h2A);
            rc(8'h06, 8'h54);
            wr(8'h06, 8'h35);
            far.lock(7'h11);
            rc(8'h06, 8'h35);
            wr(8'h06, 8'h34);
            far.lock(7'h11);
            rc(8'h06, 8'h22);
            $display("t_auto done");
        end
    endtask
    task t_remap;
        begin
            wr(8'h07, 8'h44);
            wr(8'h08, 8'h60);
            req(7'h30, 1'b1, 1'b0, 7'h22);
            req(7'h11, 1'b1, 1'b0, 7'h11);
            req(7'h05, 1'b0, 1'b0, 7'h00);
            wr(8'h07, 8'h00);
            req(7'h30, 1'b0, 1'b1, 7'h00);
            wr(8'h08, 8'h00);
            req(7'h00, 1'b0, 1'b0, 7'h00);
            wr(8'h06, 8'h01);
            req(7'h00, 1'b0, 1'b1, 7'h00);
            $display("t_remap done");
        end
    endtask
    task t_crc;
        begin
            input_clock_present = 1'b1;
            link_detect_pin = 1'b1;
            repeat (8) @(negedge mclk);
            rc(8'h0C, 8'h05);
            far.errs(3, 1'b0);
            rc(8'h0C, 8'h07);
            rc(8'h0A, 8'h03);
            far.errs(1, 1'b1);
            rc(8'h0C, 8'h0F);
            far.lose;
            rc(8'h0C, 8'h15);
            pulse_ctl(1'b1);
            rc(8'h0A, 8'h00);
            rc(8'h0C, 8'h05);
            far.errs(1, 1'b1);
            pulse_ctl(1'b0);
            rc(8'h0C, 8'h05);
            @(negedge mclk) ce = 1'b0;
            far.errs(2, 1'b0);
            @(negedge mclk) ce = 1'b1;
            rc(8'h0A, 8'h01);
            rc(8'h0C, 8'h05);
            link_detect_pin = 1'b0;
            repeat (8) @(negedge mclk);
            rc(8'h0C, 8'h04);
            $display("t_crc done");
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        err_count = 0;
        total_checks = 0;
        {ce, rst} = 2'b11;
        {reg_wr, reg_rd, selftest_start, crc_clear, req_valid} = 5'h00;
        {input_clock_present, link_detect_pin} = 2'b00;
        {reg_addr, reg_wdata, req_addr} = 23'h000000;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        t_reset;
        t_auto;
        t_remap;
        t_crc;
        finish_test;
    end
    initial begin
        #40000;
        err_count = err_count + 1;
        finish_test;
    end
endmodule // tb
